// [shared/aot_pkg.sv]
/*
 * Shared constants and types for the converter back end: register map,
 * control field layout, reset values, hold timing and state records.
 * Assumes a single 250 MHz clock that is also the sampling clock.
 */
package aot_pkg;
    // Geometry
    localparam int NCH = 4;
    localparam int CODE_W = 12;
    localparam int MAG_TOP_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EVT_W = NCH + 1;
    localparam int EVT_TS_BIT = NCH;

    // Clock and hold timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int HOLD_BASE_CYC = 8;
    localparam int HOLD_CNT_W = 11;
    localparam int HOLD_SEL_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_THRESH = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_LIVE = 8'h14;

    // Reset values and encodings
    localparam logic [MAG_TOP_W-1:0] THRESH_RESET = 8'hFF;
    localparam logic [1:0] TRIG_MODE_TIMESTAMP = 2'h3;

    // Control register, bit 0 upward: overrange_detect_enable, hold_sel, ts_recv_en,
    // ts_link_en, trig_en, trig_mode
    typedef struct packed {
        logic [1:0] trig_mode;
        logic trig_en;
        logic ts_link_en;
        logic ts_recv_en;
        logic [HOLD_SEL_W-1:0] hold_sel;
        logic overrange_detect_enable;
    } aot_ctrl_t;
    localparam int CTRL_W = $bits(aot_ctrl_t);
    localparam aot_ctrl_t CTRL_RESET = '0;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } aot_bus_req_t;

    // Hold timer state
    typedef struct packed {
        logic [HOLD_CNT_W-1:0] cnt;
        logic pin;
    } aot_hold_st_t;

    // Main block state
    typedef struct packed {
        aot_ctrl_t ctrl;
        logic [MAG_TOP_W-1:0] thr;
        logic [EVT_W-1:0] ien;
        logic [EVT_W-1:0] status;
        logic [NCH-1:0][CODE_W-1:0] s0;
        logic v0;
        logic ts_meta;
        logic ts_sync;
        logic ts_prev;
        logic [NCH-1:0][CODE_W-1:0] s1;
        logic v1;
        logic [NCH-1:0][CODE_W-1:0] link;
        logic lv;
        logic trig;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } aot_st_t;
endpackage

// [logic/aot_hold_timer.sv]
/*
 * One over-range pin with its hold counter.
 * Assumes the event input is a per-cycle compare result and that the
 * enable and hold select come from registers in the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module aot_hold_timer
    import aot_pkg::*;
#(
    parameter int HOLD_BASE = HOLD_BASE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic enable_i,
    input wire logic [aot_pkg::HOLD_SEL_W-1:0] hold_sel_i,
    input wire logic event_i,
    // Pin
    output logic pin_o
);
    aot_hold_st_t q, d;
    logic [HOLD_CNT_W-1:0] len;

    // Length is the base doubled once per select step
    assign len = HOLD_CNT_W'(HOLD_BASE) << hold_sel_i;

    // Reload on each event so the pulse runs from the last one
    always_comb begin
        d = q;
        if (!enable_i) begin
            d.pin = 1'b0;
            d.cnt = '0;
        end else if (event_i) begin
            d.pin = 1'b1;
            d.cnt = len - HOLD_CNT_W'(1);
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - HOLD_CNT_W'(1);
        end else begin
            d.pin = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_o = q.pin;

    // Cycles since last event, zero when unknown
    logic [HOLD_CNT_W-1:0] since_q;
    always_ff @(posedge clk) begin
        if (!resetn || !enable_i || (hold_sel_i != $past(hold_sel_i))) begin
            since_q <= '0;
        end else if (event_i) begin
            since_q <= HOLD_CNT_W'(1);
        end else if (since_q != '0 && since_q != '1) begin
            since_q <= since_q + HOLD_CNT_W'(1);
        end
    end

    AST_HOLD_LEN: assert property (@(posedge clk) disable iff (!resetn)
        (since_q != '0 && enable_i) |-> (q.pin == (since_q <= len)))
        else $error("Over-range pulse length does not match hold select");
    AST_HOLD_DIS: assert property (@(posedge clk) disable iff (!resetn)
        !enable_i |=> !q.pin)
        else $error("Over-range pin high while detection disabled");
    COV_HOLD_RETRIG: cover property (@(posedge clk) disable iff (!resetn)
        q.pin && event_i && q.cnt != '0);
endmodule
`default_nettype wire

// [logic/aot_core.sv]
/*
 * Digital back end of a four-channel converter: sample capture, link word
 * forming with timestamp insertion, over-range detection with held pins,
 * trigger repeat, registers and interrupt.
 * Assumes clk is the sampling clock, the converter cores present one code
 * per channel per cycle, and the register master follows the plain
 * strobe protocol with read data in the following cycle.
 */
// Local design decisions: strobed register access and the placing of the registers.
// Notes on behaviour
// - A new sample of each channel is taken on every rising clock edge outside foreground calibration.
// - Samples are signed, negative when the inverting input is higher.
// - Codes are 12-bit two's complement, -2048 to +2047.
// - Magnitude is 11 bits, -2048 maps to 2047; top eight bits compared.
// - Top eight magnitude bits are compared against the programmable threshold.
// - One threshold serves all four channels.
// - Over-range detection runs only while its enable bit is 1.
// - Channel flag is 1 when magnitude bits reach the threshold, else 0.
// - Four over-range pins, channels A, B, C, D in that order.
// - Pin holds 8 to 1024 cycles after the last event, by 3-bit select.
// - Timestamp is retimed and repeated on trigger out when enabled, mode 3.
// - Timestamp input may be asynchronous; sampled with the analog inputs.
// - Timestamp bit has the same latency as the samples.
// - Timestamp goes on the link only while its output enable is set.
// - When active, timestamp replaces the word LSB; sample kept in 11:1.
// - Timestamp function works only with the receiver enable set.
// - Sampling stops in foreground calibration, continues in background.
`timescale 1ns/1ns
`default_nettype none
module aot_core (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Converter cores
    input wire logic [aot_pkg::NCH-1:0][aot_pkg::CODE_W-1:0] core_code,
    input wire logic cal_fg_active,
    input wire logic timestamp_in,
    // Register port
    input wire aot_pkg::aot_bus_req_t bus_req,
    output logic [aot_pkg::DATA_W-1:0] rd_data,
    // Serial link words
    output logic [aot_pkg::NCH-1:0][aot_pkg::CODE_W-1:0] link_word,
    output logic link_valid,
    // Pins
    output logic overrange_out_a,
    output logic overrange_out_b,
    output logic overrange_out_c,
    output logic overrange_out_d,
    output logic trigger_out,
    output logic irq
);
    import aot_pkg::*;

    aot_st_t q, d;
    logic [NCH-1:0] hit;
    logic [NCH-1:0] pin;
    logic ts_active;
    logic trig_cond;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] clr;

    // Top eight bits of the saturated magnitude
    function automatic logic [MAG_TOP_W-1:0] mag_top(input logic [CODE_W-1:0] c);
        logic [CODE_W-1:0] neg;
        logic [CODE_W-2:0] mag;
        neg = '0;
        mag = '0;
        neg = CODE_W'(0) - c;
        if (!c[CODE_W-1]) begin
            mag = c[CODE_W-2:0];
        end else if (neg[CODE_W-1]) begin
            mag = '1; // most negative code saturates
        end else begin
            mag = neg[CODE_W-2:0];
        end
        mag_top = mag[CODE_W-2 -: MAG_TOP_W];
    endfunction

    // Timestamp is only used with the receiver on
    assign ts_active = q.ctrl.ts_recv_en && q.ctrl.ts_link_en;
    assign trig_cond = q.ctrl.ts_recv_en && q.ctrl.trig_en
        && (q.ctrl.trig_mode == TRIG_MODE_TIMESTAMP);

    // Per-channel compare and held pin, one shared threshold
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
            assign hit[ch] = q.ctrl.overrange_detect_enable && q.v0
                && (mag_top(q.s0[ch]) >= q.thr);
            aot_hold_timer #(
                .HOLD_BASE(HOLD_BASE_CYC)
            ) u_hold (
                .clk(clk),
                .resetn(resetn),
                .enable_i(q.ctrl.overrange_detect_enable),
                .hold_sel_i(q.ctrl.hold_sel),
                .event_i(hit[ch]),
                .pin_o(pin[ch])
            );
        end
    endgenerate

    // Sticky events: channel over-range and timestamp rising edge
    assign evt = {q.ts_sync && !q.ts_prev && q.ctrl.ts_recv_en, hit};
    assign clr = (bus_req.wr && bus_req.addr == REG_IRQ_CLEAR)
        ? bus_req.wdata[EVT_W-1:0] : '0;

    // Next state
    always_comb begin
        d = q;

        // Capture stage, stalled by foreground calibration only
        d.v0 = !cal_fg_active;
        if (!cal_fg_active) begin
            d.s0 = core_code;
        end

        // Timestamp synchroniser, first flop feeds only the second
        d.ts_meta = timestamp_in;
        d.ts_sync = q.ts_meta;
        d.ts_prev = q.ts_sync;

        // Extra stage so samples match the synchroniser delay
        d.s1 = q.s0;
        d.v1 = q.v0;

        // Link words
        d.lv = q.v1;
        for (int i = 0; i < NCH; i++) begin
            if (ts_active) begin
                d.link[i] = {q.s1[i][CODE_W-1:1], q.ts_sync};
            end else begin
                d.link[i] = q.s1[i];
            end
        end

        // Trigger repeat
        d.trig = trig_cond ? q.ts_sync : 1'b0;

        // Status: a set in the clearing cycle wins
        d.status = (q.status & ~clr) | evt;
        d.irq = |(q.status & q.ien);

        // Register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                REG_CTRL: d.ctrl = aot_ctrl_t'(bus_req.wdata[CTRL_W-1:0]);
                REG_THRESH: d.thr = bus_req.wdata[MAG_TOP_W-1:0];
                REG_IRQ_ENABLE: d.ien = bus_req.wdata[EVT_W-1:0];
                default: ;
            endcase
        end

        // Register reads, data valid in the next cycle only
        d.rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                REG_CTRL: d.rdata = DATA_W'(q.ctrl);
                REG_THRESH: d.rdata = DATA_W'(q.thr);
                REG_STATUS: d.rdata = DATA_W'(q.status);
                REG_IRQ_ENABLE: d.rdata = DATA_W'(q.ien);
                REG_LIVE: d.rdata = DATA_W'({!q.v0, q.ts_sync, pin});
                default: d.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
            q.thr <= THRESH_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs, all straight from flops
    assign rd_data = q.rdata;
    assign link_word = q.link;
    assign link_valid = q.lv;
    assign overrange_out_a = pin[0];
    assign overrange_out_b = pin[1];
    assign overrange_out_c = pin[2];
    assign overrange_out_d = pin[3];
    assign trigger_out = q.trig;
    assign irq = q.irq;

    // Checks on the sample path
    AST_RUN: assert property (@(posedge clk) disable iff (!resetn)
        (!cal_fg_active ##1 1'b1 ##1 1'b1) |=> link_valid)
        else $error("Sample lost while converting");
    AST_CAL_STALL: assert property (@(posedge clk) disable iff (!resetn)
        cal_fg_active |-> ##3 !link_valid)
        else $error("Link valid during foreground calibration");
    AST_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)
        !cal_fg_active |=> q.s0 == $past(core_code))
        else $error("Sample not captured on this edge");

    // Checks on timestamp insertion and trigger repeat
    AST_TS_ALIGN: assert property (@(posedge clk) disable iff (!resetn)
        (ts_active && !cal_fg_active) ##1 ts_active ##1 ts_active
        |=> (link_word[0][0] == $past(timestamp_in, 3))
        && (link_word[0][CODE_W-1:1] == $past(core_code[0][CODE_W-1:1], 3)))
        else $error("Timestamp not aligned with its sample");
    AST_TS_OFF: assert property (@(posedge clk) disable iff (!resetn)
        !ts_active |=> link_word[1] == $past(q.s1[1]))
        else $error("Link word altered with timestamp off");
    AST_TRIG: assert property (@(posedge clk) disable iff (!resetn)
        trig_cond |=> trigger_out == $past(q.ts_sync))
        else $error("Trigger out does not follow timestamp");
    AST_TRIG_OFF: assert property (@(posedge clk) disable iff (!resetn)
        !trig_cond |=> !trigger_out)
        else $error("Trigger out active while not selected");

    // Checks on over-range, status and interrupt
    AST_OVR_SET: assert property (@(posedge clk) disable iff (!resetn)
        (q.ctrl.overrange_detect_enable && q.v0 && mag_top(q.s0[2]) >= q.thr)
        ##1 q.ctrl.overrange_detect_enable |-> overrange_out_c)
        else $error("Over-range pin not raised at threshold");
    AST_OVERRANGE_DETECT_ENABLE: assert property (@(posedge clk) disable iff (!resetn)
        !q.ctrl.overrange_detect_enable |=> !(overrange_out_a || overrange_out_b
        || overrange_out_c || overrange_out_d))
        else $error("Over-range pin high while disabled");
    AST_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        hit[0] |=> q.status[0])
        else $error("Over-range event not recorded");
    AST_IRQ: assert property (@(posedge clk) disable iff (!resetn)
        |(q.status & q.ien) |=> irq)
        else $error("Interrupt not raised for enabled event");

    // Main scenarios
    COV_OVR: cover property (@(posedge clk) disable iff (!resetn)
        $rose(overrange_out_a));
    COV_TS_LINK: cover property (@(posedge clk) disable iff (!resetn)
        ts_active && link_valid && link_word[0][0]);
    COV_TRIG: cover property (@(posedge clk) disable iff (!resetn)
        $rose(trigger_out));
    COV_CAL: cover property (@(posedge clk) disable iff (!resetn)
        link_valid ##1 !link_valid ##1 link_valid);
endmodule
`default_nettype wire

// [tb/aot_link_sink.sv]
/* Downstream receiver model: watches link valid and over-range pins.
   Assumes one clock shared with the converter back end. */
`timescale 1ns/1ns
`default_nettype none
module aot_link_sink
    import aot_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // From the converter
    input wire logic link_valid,
    input wire logic [aot_pkg::NCH-1:0] overrange_pins,
    // Gain management view
    output logic gain_cut,
    output logic [15:0] flag_events
);
    logic gain_cut_q;
    logic [15:0] flag_events_q;
    logic any_q;
    // Cut gain on a flag, restore only once valid samples show no flag
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gain_cut_q <= 1'b0;
            flag_events_q <= 16'h0000;
            any_q <= 1'b0;
        end else begin
            any_q <= |overrange_pins;
            if (|overrange_pins) begin
                gain_cut_q <= 1'b1;
            end else if (link_valid) begin
                gain_cut_q <= 1'b0;
            end
            if ((|overrange_pins) && !any_q) begin
                flag_events_q <= flag_events_q + 16'h0001;
            end
        end
    end
    assign gain_cut = gain_cut_q;
    assign flag_events = flag_events_q;
endmodule
`default_nettype wire

// [tb/tb.sv]
/* Self-checking bench for aot_core: registers, link words, pins, irq, trigger.
   Assumes the package and the sink model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import aot_pkg::*;
    logic clk, resetn, cal_fg_active, timestamp_in, link_valid, trigger_out, irq, gain_cut;
    logic [NCH-1:0][CODE_W-1:0] core_code;
    logic [NCH-1:0][CODE_W-1:0] link_word;
    aot_bus_req_t bus_req;
    logic [DATA_W-1:0] rd_data;
    wire logic [3:0] pins;
    logic [15:0] flag_events;
    int mismatches, comparisons, cycles;
    aot_core u_aot_core (.clk(clk), .resetn(resetn), .core_code(core_code), .cal_fg_active(cal_fg_active),
        .timestamp_in(timestamp_in), .bus_req(bus_req), .rd_data(rd_data), .link_word(link_word),
        .link_valid(link_valid), .overrange_out_a(pins[0]), .overrange_out_b(pins[1]),
        .overrange_out_c(pins[2]), .overrange_out_d(pins[3]), .trigger_out(trigger_out), .irq(irq));
    aot_link_sink u_aot_link_sink (.clk(clk), .resetn(resetn), .link_valid(link_valid),
        .overrange_pins(pins), .gain_cut(gain_cut), .flag_events(flag_events));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard, well above the roughly 9k cycles of the run
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One-cycle strobes, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(rd_data, exp, "read data");
    endtask
    task automatic link_case(input logic [11:0] code, input logic ts, input logic [11:0] exp);
        @(posedge clk);
        core_code[3] <= code;
        timestamp_in <= ts;
        repeat (3) @(posedge clk);
        #1;
        chk({20'h0_0000, link_word[3]}, {20'h0_0000, exp}, "link word");
        chk({31'h0, link_valid}, 32'h0000_0001, "link valid");
    endtask
    // One-cycle sample on one channel, then count how long its pin stays up
    task automatic pulse(input int ch, input logic [11:0] code, input int exp_len);
        int n;
        n = 0;
        @(posedge clk);
        core_code[ch] <= code;
        @(posedge clk);
        core_code[ch] <= 12'h000;
        repeat (1100) begin
            @(posedge clk);
            #1;
            if (pins[ch] === 1'b1) n++;
            if ((pins & ~(4'b0001 << ch)) !== 4'h0) n += 5000;
        end
        chk(32'(n), 32'(exp_len), "pin length");
    endtask
    task automatic t_regs;
        rd_chk(REG_THRESH, 32'h0000_00FF);
        rd_chk(REG_CTRL, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'h0000_0000);
        wr(REG_STATUS, 32'hFFFF_FFFF);
        rd_chk(REG_STATUS, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_01D0);
        rd_chk(REG_CTRL, 32'h0000_01D0);
        $display("test regs done");
    endtask
    task automatic t_link;
        wr(REG_CTRL, 32'h0000_0000);
        link_case(12'h801, 1'b0, 12'h801);
        wr(REG_CTRL, 32'h0000_0030);
        link_case(12'h5A4, 1'b1, 12'h5A5);
        link_case(12'h5A5, 1'b0, 12'h5A4);
        wr(REG_CTRL, 32'h0000_0020);
        link_case(12'h5A4, 1'b1, 12'h5A4);
        wr(REG_CTRL, 32'h0000_0010);
        link_case(12'h5A4, 1'b1, 12'h5A4);
        $display("test link done");
    endtask
    task automatic t_cal;
        @(posedge clk);
        cal_fg_active <= 1'b1;
        @(posedge clk);
        cal_fg_active <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, link_valid}, 32'h0000_0000, "stall");
        @(posedge clk);
        #1;
        chk({31'h0, link_valid}, 32'h0000_0001, "resume");
        $display("test cal done");
    endtask
    task automatic t_overrange;
        core_code <= '0;
        timestamp_in <= 1'b0;
        wr(REG_THRESH, 32'h0000_00FE);
        wr(REG_CTRL, 32'h0000_0001);
        pulse(0, 12'h7F0, 8);
        pulse(0, 12'h7EF, 0);
        pulse(3, 12'h800, 8);
        pulse(2, 12'h810, 8);
        wr(REG_CTRL, 32'h0000_000F);
        pulse(1, 12'h7FF, 1024);
        wr(REG_CTRL, 32'h0000_0005);
        pulse(1, 12'h7FF, 32);
        wr(REG_CTRL, 32'h0000_0000);
        pulse(0, 12'h7FF, 0);
        chk({16'h0000, flag_events}, 32'h0000_0005, "flag count");
        chk({31'h0, gain_cut}, 32'h0000_0000, "gain restored");
        $display("test overrange done");
    endtask
    task automatic t_irq;
        wr(REG_IRQ_CLEAR, 32'h0000_001F);
        rd_chk(REG_IRQ_CLEAR, 32'h0000_0000);
        rd_chk(REG_STATUS, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0001);
        wr(REG_IRQ_ENABLE, 32'h0000_0001);
        pulse(3, 12'h7FF, 8);
        chk({31'h0, irq}, 32'h0000_0000, "irq masked");
        rd_chk(REG_STATUS, 32'h0000_0008);
        wr(REG_IRQ_ENABLE, 32'h0000_0008);
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0000_0001, "irq raised");
        wr(REG_IRQ_CLEAR, 32'h0000_0008);
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
        $display("test irq done");
    endtask
    task automatic t_trigger;
        wr(REG_CTRL, 32'h0000_01D0);
        @(posedge clk);
        timestamp_in <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, trigger_out}, 32'h0000_0000, "trigger early");
        @(posedge clk);
        #1;
        chk({31'h0, trigger_out}, 32'h0000_0001, "trigger");
        wr(REG_CTRL, 32'h0000_0150);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, trigger_out}, 32'h0000_0000, "trigger mode");
        rd_chk(REG_LIVE, 32'h0000_0010);
        $display("test trigger done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        resetn = 1'b0;
        cal_fg_active = 1'b0;
        timestamp_in = 1'b0;
        core_code = '0;
        bus_req = '0;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_link;
        t_cal;
        t_overrange;
        t_irq;
        t_trigger;
        close_out;
    end
endmodule
`default_nettype wire
